// File: hdl/watchdog_interval_timer.sv
/*
 * Watchdog / interval timer with AXI4-Lite register access.
 * Assumes the oscillator ticks arrive as one-cycle enables synchronous to
 * sys_clk, and that the chip reset controller drives other_reset_active.
 */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
    import wdt_pkg::*;
(
    input wire logic sys_clk, // System clock, 125 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic watchdog_enable_fuse, // Configuration fuse enabling watchdog mode.
    input wire logic wdt_osc_tick, // Dedicated oscillator tick enable.
    input wire logic alt_clk_tick, // Alternate clock tick enable.
    input wire logic other_reset_active, // Power-on, brownout or pin reset active.
    input wire logic power_down, // Chip is in power down mode.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic wdt_reset_out, // Internal chip reset request.
    output logic osc_restart, // Main oscillator restart request.
    output logic irq // Level interrupt.
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [COUNT_W-1:0] period_of(input logic [CTL_SEL_W-1:0] sel);
        period_of = COUNT_W'(1) << (BASE_TICKS_LOG2 + int'(sel));
    endfunction

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RRESP = 3'b100
    } bus_state_t;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bus_state_t bus_q, bus_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    wr_req_t wr_q, wr_d;
    rd_rsp_t rd_q, rd_d;
    logic [1:0] bresp_q, bresp_d;
    logic [7:0] ctl_q, ctl_d;
    logic ctl_locked_q, ctl_locked_d;
    logic key_armed_q, key_armed_d;
    logic [COUNT_W-1:0] cnt_q, cnt_d;
    logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
    logic [7:0] pulse_q, pulse_d;
    logic osc_q, osc_d;

    logic do_write, wr_byte0, fuse_run, tick, overflow, feed_wr, feed_ok, feed_bad;
    logic wdt_overflow;
    logic [7:0] wbyte;

    assign s_axi_awready = (bus_q == BUS_IDLE) && !aw_held_q;
    assign s_axi_wready = (bus_q == BUS_IDLE) && !w_held_q;
    assign s_axi_arready = (bus_q == BUS_IDLE) && !s_axi_awvalid && !aw_held_q;
    assign s_axi_bvalid = (bus_q == BUS_WRESP);
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = (bus_q == BUS_RRESP);
    assign s_axi_rdata = rd_q.data;
    assign s_axi_rresp = rd_q.resp;
    assign irq = |(ist_q & ien_q);
    assign wdt_reset_out = (pulse_q != 8'h00);
    assign osc_restart = osc_q;

    // The held flags are cleared in the very cycle the write is accepted,
    // so acceptance is read from the state change instead.
    assign do_write = (bus_q == BUS_IDLE) && (bus_d == BUS_WRESP);
    assign wr_byte0 = do_write && wr_d.strb[0];
    assign wbyte = wr_d.data[7:0];

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    always_comb begin
        bus_d = bus_q;
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        wr_d = wr_q;
        rd_d = rd_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            wr_d.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wr_d.data = s_axi_wdata;
            wr_d.strb = s_axi_wstrb;
        end
        case (bus_q)
            BUS_IDLE: begin
                if (aw_held_d && w_held_d) begin
                    aw_held_d = 1'b0;
                    w_held_d = 1'b0;
                    bus_d = BUS_WRESP;
                    bresp_d = (wr_d.addr == ADDR_CONTROL || wr_d.addr == ADDR_FEED
                        || wr_d.addr == ADDR_IRQ_CLEAR || wr_d.addr == ADDR_IRQ_ENABLE)
                        ? RESP_OKAY : RESP_SLVERR;
                end else if (s_axi_arvalid && s_axi_arready) begin
                    bus_d = BUS_RRESP;
                    rd_d.resp = RESP_OKAY;
                    case (s_axi_araddr)
                        ADDR_CONTROL: rd_d.data = {24'h000000, ctl_q};
                        ADDR_IRQ_STATUS: rd_d.data = {30'h0, ist_q};
                        ADDR_IRQ_ENABLE: rd_d.data = {30'h0, ien_q};
                        ADDR_COUNT: rd_d.data = {11'h0, cnt_q};
                        ADDR_FEED, ADDR_IRQ_CLEAR: rd_d.data = 32'h00000000;
                        default: begin
                            rd_d.data = 32'h00000000;
                            rd_d.resp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            BUS_WRESP: if (s_axi_bready) bus_d = BUS_IDLE;
            BUS_RRESP: if (s_axi_rready) bus_d = BUS_IDLE;
            default: bus_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus_q <= BUS_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_q <= '0;
            rd_q <= '0;
            bresp_q <= RESP_OKAY;
        end else begin
            bus_q <= bus_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            bresp_q <= bresp_d;
        end
    end

    // ------------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------------
    // The fuse wins over the run bit, so software can never halt the
    // watchdog; in watchdog mode the dedicated oscillator is always used
    // because the alternate source may be the very clock that failed.
    assign fuse_run = watchdog_enable_fuse || ctl_q[CTL_RUN_BIT];
    assign tick = (watchdog_enable_fuse || ctl_q[CTL_CLK_BIT])
        ? wdt_osc_tick : alt_clk_tick;
    assign overflow = fuse_run && tick && !other_reset_active
        && (cnt_q == period_of(ctl_q[CTL_SEL_MSB -: CTL_SEL_W]) - COUNT_W'(1));
    assign feed_wr = wr_byte0 && (wr_d.addr == ADDR_FEED);
    assign feed_ok = feed_wr && key_armed_q && (wbyte == FEED_KEY_SECOND);
    assign feed_bad = feed_wr && !feed_ok && (wbyte != FEED_KEY_FIRST);
    assign wdt_overflow = overflow && watchdog_enable_fuse;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A wrong feed never touches the count, so the overflow stays at its
    // scheduled time however software misbehaves.
    always_comb begin
        cnt_d = cnt_q;
        if (feed_ok) begin
            cnt_d = '0;
        end else if (other_reset_active) begin
            cnt_d = '0;
        end else if (fuse_run && tick) begin
            cnt_d = overflow ? '0 : cnt_q + COUNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Control register and feed key
    // ------------------------------------------------------------------
    always_comb begin
        ctl_d = ctl_q;
        ctl_locked_d = ctl_locked_q;
        key_armed_d = key_armed_q;
        if (wr_byte0 && (wr_d.addr == ADDR_CONTROL)) begin
            if (!(watchdog_enable_fuse && ctl_locked_q)) begin
                ctl_d = (ctl_q & ~CTL_WR_MASK) | (wbyte & CTL_WR_MASK);
                ctl_locked_d = 1'b1;
            end
        end
        if (feed_wr) begin
            key_armed_d = (wbyte == FEED_KEY_FIRST);
        end
        if (watchdog_enable_fuse) begin
            ctl_d[CTL_RUN_BIT] = 1'b1;
        end
        if (feed_ok) begin
            ctl_d[CTL_OVF_BIT] = 1'b0;
        end
        if (overflow) begin
            ctl_d[CTL_OVF_BIT] = 1'b1;
        end
        // A watchdog reset reloads the control register with the chip reset value
        // plus the overflow flag, but keeps the clock choice and reopens the single write.
        if (wdt_overflow) begin
            ctl_d = CTL_WDT_RST_VALUE;
            ctl_d[CTL_CLK_BIT] = ctl_q[CTL_CLK_BIT];
            ctl_locked_d = 1'b0;
            key_armed_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= CTL_RST_VALUE;
            ctl_locked_q <= 1'b0;
            key_armed_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            ctl_locked_q <= ctl_locked_d;
            key_armed_q <= key_armed_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and enable
    // ------------------------------------------------------------------
    always_comb begin
        ist_d = ist_q;
        ien_d = ien_q;
        if (wr_byte0 && (wr_d.addr == ADDR_IRQ_CLEAR)) begin
            ist_d = ist_q & ~wbyte[IRQ_W-1:0];
        end
        if (wr_byte0 && (wr_d.addr == ADDR_IRQ_ENABLE)) begin
            ien_d = wbyte[IRQ_W-1:0];
        end
        // Events are applied after the clear, so a set in the same cycle wins.
        if (overflow) begin
            ist_d[IRQ_OVF_BIT] = 1'b1;
        end
        if (feed_bad) begin
            ist_d[IRQ_BADFEED_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ist_q <= '0;
            ien_q <= '0;
        end else begin
            ist_q <= ist_d;
            ien_q <= ien_d;
        end
    end

    // ------------------------------------------------------------------
    // Reset pulse and oscillator restart
    // ------------------------------------------------------------------
    always_comb begin
        pulse_d = (pulse_q != 8'h00) ? pulse_q - 8'h01 : 8'h00;
        osc_d = osc_q && power_down;
        if (wdt_overflow) begin
            pulse_d = 8'(RESET_PULSE_CYC);
            osc_d = power_down;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= 8'h00;
            osc_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            osc_q <= osc_d;
        end
    end

endmodule
`default_nettype wire

// File: hdl/wdt_pkg.sv
/*
 * Package for the watchdog / interval timer: register map, control field
 * positions, feed keys, timing constants and the bus carrier structs.
 * Assumes a 125 MHz system clock and an AXI4-Lite register bus.
 */
package wdt_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Registers are word indexed: the byte address is four times the index.
    localparam int ADDR_W = 10;
    localparam logic [7:0] CTL_INDEX = 8'ha7;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {CTL_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FEED = 10'h2a0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 10'h2a4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 10'h2a8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 10'h2ac;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 10'h2b0;

    // ------------------------------------------------------------------
    // Control field layout
    // ------------------------------------------------------------------
    localparam int CTL_OVF_BIT = 5;
    localparam int CTL_RUN_BIT = 4;
    localparam int CTL_CLK_BIT = 3;
    localparam int CTL_SEL_MSB = 2;
    localparam int CTL_SEL_W = 3;
    localparam logic [7:0] CTL_RST_VALUE = 8'h10;
    localparam logic [7:0] CTL_WDT_RST_VALUE = 8'h30;
    localparam logic [7:0] CTL_WR_MASK = 8'h1f;

    localparam logic [7:0] FEED_KEY_FIRST = 8'h1e;
    localparam logic [7:0] FEED_KEY_SECOND = 8'he1;

    localparam int IRQ_W = 2;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_BADFEED_BIT = 1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 125;
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * SYS_CLK_MHZ) / 1000;
    localparam int COUNT_W = 21;
    localparam int BASE_TICKS_LOG2 = 13;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_rsp_t;

endpackage

// File: testbench/core_bus_model.sv
/* Bus master model of the processor core software.
   Assumes the bench has released reset before any task is called. */
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
    import wdt_pkg::*;
(
    input wire logic clk, // Clock.
    output logic [ADDR_W-1:0] awaddr, // Write address.
    output logic awvalid, // Address valid.
    input wire logic awready, // Address ready.
    output logic [31:0] wdata, // Write data.
    output logic wvalid, // Data valid.
    input wire logic wready, // Data ready.
    input wire logic [1:0] bresp, // Response.
    input wire logic bvalid, // Response valid.
    output logic bready, // Response ready.
    output logic [ADDR_W-1:0] araddr, // Read address.
    output logic arvalid, // Read valid.
    input wire logic arready, // Read ready.
    input wire logic [31:0] rdata, // Read data.
    input wire logic [1:0] rresp, // Read response.
    input wire logic rvalid, // Data valid.
    output logic rready // Data ready.
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        @(posedge clk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic feed;
        logic [1:0] r;
        wr(ADDR_FEED, {24'h0, FEED_KEY_FIRST}, r);
        wr(ADDR_FEED, {24'h0, FEED_KEY_SECOND}, r);
    endtask
endmodule
`default_nettype wire

// File: testbench/watchdog_interval_timer_tb.sv
/* Self-checking bench for the watchdog timer.
   Assumes the core bus model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_tb
    import wdt_pkg::*;
;
    logic sys_clk, resetn, fuse, osc_tick, alt_tick, other_rst, pdown, rst_out, osc_rst, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    watchdog_interval_timer DUT (.sys_clk(sys_clk), .resetn(resetn),
        .watchdog_enable_fuse(fuse), .wdt_osc_tick(osc_tick), .alt_clk_tick(alt_tick),
        .other_reset_active(other_rst), .power_down(pdown), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wdt_reset_out(rst_out), .osc_restart(osc_rst), .irq(irq));
    core_bus_model m (.clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        m.rd(a, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, er});
    endtask
    task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        m.wr(a, d, r);
        check({30'h0, r}, 32'h0);
    endtask
    task automatic wait_hi(input bit use_rst, output int n);
        n = 0;
        while ((use_rst ? rst_out : irq) !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic do_reset(input logic f);
        fuse <= f;
        resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask
    task automatic t_interval;
        int n;
        rdc(ADDR_CONTROL, {24'h0, CTL_RST_VALUE}, RESP_OKAY);
        rdc(10'h000, 32'h0, RESP_SLVERR);
        w(ADDR_IRQ_ENABLE, 32'h3);
        w(ADDR_CONTROL, 32'h18);
        m.feed();
        wait_hi(1'b0, n);
        check(32'(n > 8180 && n < 8200), 32'h1);
        check({31'h0, rst_out}, 32'h0);
        rdc(ADDR_CONTROL, 32'h38, RESP_OKAY);
        m.feed();
        rdc(ADDR_CONTROL, 32'h18, RESP_OKAY);
        w(ADDR_IRQ_CLEAR, 32'h1);
        check({31'h0, irq}, 32'h0);
        w(ADDR_CONTROL, 32'h19);
        m.feed();
        wait_hi(1'b0, n);
        check(32'(n > 16370 && n < 16390), 32'h1);
    endtask
    task automatic t_feed;
        logic [31:0] a, b;
        logic [1:0] r;
        w(ADDR_IRQ_CLEAR, 32'h3);
        w(ADDR_FEED, 32'h1e);
        rdc(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        w(ADDR_FEED, 32'he1);
        m.rd(ADDR_COUNT, a, r);
        check(32'(a < 32'h20), 32'h1);
        w(ADDR_FEED, 32'h55);
        check({31'h0, irq}, 32'h1);
        w(ADDR_FEED, 32'he1);
        m.rd(ADDR_COUNT, b, r);
        check(32'(b > a), 32'h1);
        w(ADDR_CONTROL, 32'h08);
        m.rd(ADDR_COUNT, a, r);
        repeat (20) @(posedge sys_clk);
        rdc(ADDR_COUNT, a, RESP_OKAY);
        w(ADDR_CONTROL, 32'h10);
        rdc(ADDR_COUNT, a, RESP_OKAY);
        alt_tick <= 1'b1;
        repeat (20) @(posedge sys_clk);
        m.rd(ADDR_COUNT, b, r);
        check(32'(b > a), 32'h1);
        alt_tick <= 1'b0;
    endtask
    task automatic t_fuse;
        int n;
        do_reset(1'b1);
        m.feed();
        w(ADDR_CONTROL, 32'h00);
        rdc(ADDR_CONTROL, 32'h10, RESP_OKAY);
        w(ADDR_CONTROL, 32'h0f);
        rdc(ADDR_CONTROL, 32'h10, RESP_OKAY);
        other_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rdc(ADDR_COUNT, 32'h0, RESP_OKAY);
        other_rst <= 1'b0;
        pdown <= 1'b1;
        wait_hi(1'b1, n);
        check(32'(n > 8180 && n < 8200), 32'h1);
        @(posedge sys_clk);
        check({31'h0, osc_rst}, 32'h1);
        rdc(ADDR_CONTROL, {24'h0, CTL_WDT_RST_VALUE}, RESP_OKAY);
        pdown <= 1'b0;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        {resetn, fuse, alt_tick, other_rst, pdown} = '0;
        osc_tick = 1'b1;
        do_reset(1'b0);
        t_interval;
        t_feed;
        t_fuse;
        end_sim;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            end_sim;
        end
    end
endmodule
`default_nettype wire

// File: testbench/wdt_chk.sv
/* Port-level assertions for the watchdog timer.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module wdt_chk
    import wdt_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic resetn, // Reset.
    input wire logic watchdog_enable_fuse, // Fuse.
    input wire logic other_reset_active, // Chip reset.
    input wire logic power_down, // Power down.
    input wire logic s_axi_awvalid, // Bus.
    input wire logic s_axi_awready, // Bus.
    input wire logic s_axi_wvalid, // Bus.
    input wire logic s_axi_wready, // Bus.
    input wire logic s_axi_bvalid, // Bus.
    input wire logic s_axi_arvalid, // Bus.
    input wire logic s_axi_arready, // Bus.
    input wire logic s_axi_rvalid, // Bus.
    input wire logic wdt_reset_out, // Chip reset request.
    input wire logic osc_restart, // Oscillator restart.
    input wire logic irq // Interrupt.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [7:0] pulse_q;
    logic [7:0] pulse_d;
    always_comb pulse_d = wdt_reset_out ? pulse_q + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= 8'h00;
        end else begin
            pulse_q <= pulse_d;
        end
    end
    pulse_len_a: assert property ($fell(wdt_reset_out) |-> pulse_q == RESET_PULSE_CYC)
        else $error("reset pulse length wrong");
    pulse_max_a: assert property (pulse_q <= RESET_PULSE_CYC)
        else $error("reset pulse too long");
    no_reset_int_a: assert property (!watchdog_enable_fuse |-> !wdt_reset_out)
        else $error("reset in interval mode");
    held_off_a: assert property (other_reset_active && !wdt_reset_out |=> !wdt_reset_out)
        else $error("timer active during chip reset");
    osc_cause_a: assert property ($rose(osc_restart) |-> power_down && watchdog_enable_fuse)
        else $error("oscillator restart without cause");
    osc_drop_a: assert property (osc_restart && !power_down |=> !osc_restart)
        else $error("oscillator restart stuck");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response late");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    cover property ($rose(wdt_reset_out));
    cover property ($rose(irq));
    cover property ($rose(osc_restart));
endmodule
bind watchdog_interval_timer wdt_chk u_chk (.*);
`default_nettype wire
